// ---- common/pscd_pkg.sv ----
// constants and types for the serial potentiometer command decoder
package pscd_pkg;
	// ==========================================================
	// widths and sizes
	localparam int WIPER_W = 6;
	localparam int SLOTS = 4;
	localparam int SEL_W = 2;
	localparam logic [SEL_W-1:0] DEFAULT_SETTING_SLOT = 2'h0;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int NV_WRITE_TIME_NS = 5000000;
	localparam int NV_WRITE_CYC =
		(NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// settle time is not given; plain default
	localparam int WIPER_SETTLE_DELAY_NS = 1000;
	localparam int WIPER_SETTLE_CYC =
		(WIPER_SETTLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BUSY_W = 17;
	localparam int SETTLE_W = 8;

	// ==========================================================
	// reset values and wiper step limits
	localparam logic [WIPER_W-1:0] RST_WIPER = 6'h00;
	localparam logic [WIPER_W-1:0] RST_SETTING = 6'h00;
	localparam logic [WIPER_W-1:0] WIPER_TOP = 6'h3F;
	localparam logic [WIPER_W-1:0] WIPER_BOTTOM = 6'h00;

	// ==========================================================
	// address byte field positions
	localparam int ADDR_TYPE_LSB = 4;
	localparam int ADDR_STRAP_HIGH = 3;
	localparam int ADDR_STRAP_MID = 2;
	localparam int ADDR_STRAP_LOW = 0;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	// ==========================================================
	// instruction codes
	localparam logic [3:0] OP_RD_WIPER = 4'h9;
	localparam logic [3:0] OP_WR_WIPER = 4'hA;
	localparam logic [3:0] OP_RD_SETTING = 4'hB;
	localparam logic [3:0] OP_WR_SETTING = 4'hC;
	localparam logic [3:0] OP_SETTING_TO_WIPER = 4'hD;
	localparam logic [3:0] OP_WIPER_TO_SETTING = 4'hE;
	localparam logic [3:0] OP_STEP = 4'h2;

	// ==========================================================
	// types
	typedef struct packed {
		logic [3:0] opcode;
		logic [SEL_W-1:0] reg_select;
		logic [1:0] pad;
	} pscd_instr_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_INSTR,
		ST_DATA,
		ST_ACK,
		ST_READ,
		ST_STEP
	} pscd_state_t;
endpackage

// ---- src/pscd_top.sv ----
// two-wire slave command decoder for one digital potentiometer
`timescale 1ns/10ps
module pscd_top #(
	// arbitrary identifier value
	parameter logic [3:0] DEVICE_TYPE = 4'hA,
	parameter int NV_WRITE_CYCLES = pscd_pkg::NV_WRITE_CYC
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// two-wire bus
	input wire logic i_scl,
	input wire logic i_sda,
	output logic o_sda_out,
	output logic o_sda_oe_n,
	// straps and write guard
	input wire logic i_address_strap_low,
	input wire logic i_address_strap_mid,
	input wire logic i_address_strap_high,
	input wire logic i_write_guard_n,
	// status
	output logic [pscd_pkg::WIPER_W-1:0] o_wiper_position,
	output logic o_nv_busy
);
	import pscd_pkg::*;

	// ==========================================================
	// input synchronisers
	logic [1:0] scl_sync_q;
	logic [1:0] sda_sync_q;
	logic [1:0] grd_sync_q;
	logic [2:0] strap_sync_q [2];
	logic scl_prev_q;
	logic sda_prev_q;

	always_ff @(posedge i_core_clk) begin
		scl_sync_q <= {scl_sync_q[0], i_scl};
		sda_sync_q <= {sda_sync_q[0], i_sda};
		grd_sync_q <= {grd_sync_q[0], i_write_guard_n};
		strap_sync_q[0] <= {i_address_strap_high,
			i_address_strap_mid, i_address_strap_low};
		strap_sync_q[1] <= strap_sync_q[0];
		scl_prev_q <= scl_sync_q[1];
		sda_prev_q <= sda_sync_q[1];
	end

	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign scl_rise = scl_s & ~scl_prev_q;
	assign scl_fall = ~scl_s & scl_prev_q;
	assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign bus_stop = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	// ==========================================================
	// decoder state
	pscd_state_t state_q, state_d;
	pscd_state_t after_q, after_d;
	logic [3:0] bit_cnt_q, bit_cnt_d;
	logic [7:0] shift_q, shift_d;
	pscd_instr_t instr_q, instr_d;
	logic drive_q, drive_d;
	logic [WIPER_W-1:0] wiper_q, wiper_d;
	logic [WIPER_W-1:0] setting_q [SLOTS];
	logic [WIPER_W-1:0] setting_d [SLOTS];
	logic nv_pend_q, nv_pend_d;
	logic [SEL_W-1:0] nv_sel_q, nv_sel_d;
	logic [WIPER_W-1:0] nv_val_q, nv_val_d;
	logic [BUSY_W-1:0] busy_q, busy_d;
	logic [SETTLE_W-1:0] settle_q, settle_d;
	logic [WIPER_W-1:0] out_wiper_q, out_wiper_d;

	logic busy;
	logic addr_ok;
	logic instr_ok;
	pscd_instr_t rx_instr;

	assign busy = (busy_q != '0);
	assign rx_instr = pscd_instr_t'(shift_q);

	always_comb begin
		addr_ok = 1'b0;
		if (shift_q[7:ADDR_TYPE_LSB] == DEVICE_TYPE) begin
			addr_ok = (shift_q[ADDR_STRAP_HIGH] == strap_sync_q[1][2])
				&& (shift_q[ADDR_STRAP_MID] == strap_sync_q[1][1])
				&& (shift_q[ADDR_STRAP_LOW] == strap_sync_q[1][0]);
		end
	end

	always_comb begin
		instr_ok = 1'b0;
		if (rx_instr.pad == 2'h0) begin
			case (rx_instr.opcode)
				OP_RD_WIPER, OP_WR_WIPER, OP_STEP:
					instr_ok = (rx_instr.reg_select == '0);
				OP_RD_SETTING, OP_WR_SETTING, OP_SETTING_TO_WIPER,
				OP_WIPER_TO_SETTING:
					instr_ok = 1'b1;
				default:
					instr_ok = 1'b0;
			endcase
		end
	end

	// ==========================================================
	// next-state logic
	always_comb begin
		state_d = state_q;
		after_d = after_q;
		bit_cnt_d = bit_cnt_q;
		shift_d = shift_q;
		instr_d = instr_q;
		drive_d = drive_q;
		wiper_d = wiper_q;
		setting_d = setting_q;
		nv_pend_d = nv_pend_q;
		nv_sel_d = nv_sel_q;
		nv_val_d = nv_val_q;
		busy_d = busy ? busy_q - 1'b1 : busy_q;
		settle_d = (settle_q != '0) ? settle_q - 1'b1 : settle_q;
		out_wiper_d = (settle_q == '0) ? wiper_q : out_wiper_q;

		if (bus_stop) begin
			state_d = ST_IDLE;
			drive_d = 1'b0;
			if (nv_pend_q) begin
				nv_pend_d = 1'b0;
				if (grd_sync_q[1]) begin
					setting_d[nv_sel_q] = nv_val_q;
					busy_d = BUSY_W'(NV_WRITE_CYCLES);
				end
			end
		end else if (bus_start) begin
			state_d = ST_ADDR;
			bit_cnt_d = '0;
			drive_d = 1'b0;
			nv_pend_d = 1'b0;
		end else begin
			case (state_q)
				ST_ADDR, ST_INSTR, ST_DATA: begin
					if (scl_rise && bit_cnt_q != BITS_PER_BYTE) begin
						shift_d = {shift_q[6:0], sda_s};
						bit_cnt_d = bit_cnt_q + 1'b1;
					end else if (scl_fall && bit_cnt_q == BITS_PER_BYTE) begin
						bit_cnt_d = '0;
						state_d = ST_IDLE;
						if (state_q == ST_ADDR) begin
							if (addr_ok && !busy) begin
								drive_d = 1'b1;
								state_d = ST_ACK;
								after_d = ST_INSTR;
							end
						end else if (state_q == ST_INSTR) begin
							if (instr_ok) begin
								drive_d = 1'b1;
								state_d = ST_ACK;
								instr_d = rx_instr;
								after_d = ST_IDLE;
								case (rx_instr.opcode)
									OP_RD_WIPER: begin
										after_d = ST_READ;
										shift_d = {2'h0, wiper_q};
									end
									OP_RD_SETTING: begin
										after_d = ST_READ;
										shift_d = {2'h0,
											setting_q[rx_instr.reg_select]};
									end
									OP_WR_WIPER, OP_WR_SETTING:
										after_d = ST_DATA;
									OP_SETTING_TO_WIPER: begin
										wiper_d =
											setting_q[rx_instr.reg_select];
										settle_d =
											SETTLE_W'(WIPER_SETTLE_CYC);
									end
									OP_WIPER_TO_SETTING: begin
										nv_pend_d = 1'b1;
										nv_sel_d = rx_instr.reg_select;
										nv_val_d = wiper_q;
									end
									OP_STEP:
										after_d = ST_STEP;
									default:
										after_d = ST_IDLE;
								endcase
							end
						end else begin
							drive_d = 1'b1;
							state_d = ST_ACK;
							after_d = ST_IDLE;
							if (instr_q.opcode == OP_WR_WIPER) begin
								wiper_d = shift_q[WIPER_W-1:0];
								settle_d = '0;
							end else begin
								nv_pend_d = 1'b1;
								nv_sel_d = instr_q.reg_select;
								nv_val_d = shift_q[WIPER_W-1:0];
							end
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						state_d = after_q;
						drive_d = (after_q == ST_READ) ? ~shift_q[7] : 1'b0;
					end
				end
				ST_READ: begin
					if (scl_rise) begin
						bit_cnt_d = bit_cnt_q + 1'b1;
					end else if (scl_fall) begin
						if (bit_cnt_q == BITS_PER_BYTE) begin
							drive_d = 1'b0;
							state_d = ST_IDLE;
						end else begin
							shift_d = {shift_q[6:0], 1'b0};
							drive_d = ~shift_q[6];
						end
					end
				end
				ST_STEP: begin
					if (scl_rise) begin
						if (sda_s && wiper_q != WIPER_TOP) begin
							wiper_d = wiper_q + 1'b1;
						end else if (!sda_s && wiper_q != WIPER_BOTTOM) begin
							wiper_d = wiper_q - 1'b1;
						end
						settle_d = '0;
					end
				end
				default: begin
					state_d = ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// state registers
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_IDLE;
			after_q <= ST_IDLE;
			bit_cnt_q <= '0;
			shift_q <= '0;
			instr_q <= '0;
			drive_q <= 1'b0;
			wiper_q <= RST_WIPER;
			for (int i = 0; i < SLOTS; i++) begin
				setting_q[i] <= RST_SETTING;
			end
			nv_pend_q <= 1'b0;
			nv_sel_q <= DEFAULT_SETTING_SLOT;
			nv_val_q <= RST_SETTING;
			busy_q <= '0;
			settle_q <= '0;
			out_wiper_q <= RST_WIPER;
			o_sda_out <= 1'b0;
			o_sda_oe_n <= 1'b1;
			o_wiper_position <= RST_WIPER;
			o_nv_busy <= 1'b0;
		end else begin
			state_q <= state_d;
			after_q <= after_d;
			bit_cnt_q <= bit_cnt_d;
			shift_q <= shift_d;
			instr_q <= instr_d;
			drive_q <= drive_d;
			wiper_q <= wiper_d;
			setting_q <= setting_d;
			nv_pend_q <= nv_pend_d;
			nv_sel_q <= nv_sel_d;
			nv_val_q <= nv_val_d;
			busy_q <= busy_d;
			settle_q <= settle_d;
			out_wiper_q <= out_wiper_d;
			o_sda_out <= 1'b0;
			o_sda_oe_n <= ~drive_d;
			o_wiper_position <= out_wiper_d;
			o_nv_busy <= (busy_d != '0);
		end
	end
endmodule

// ---- tb/pscd_top_asserts.sv ----
// port assertions for the potentiometer command decoder
`timescale 1ns/10ps
module pscd_top_asserts #(
	parameter int NV_WRITE_CYCLES = pscd_pkg::NV_WRITE_CYC
) (
	// watched ports
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_write_guard_n,
	input wire logic o_sda_out,
	input wire logic o_sda_oe_n,
	input wire logic [pscd_pkg::WIPER_W-1:0] o_wiper_position,
	input wire logic o_nv_busy
);
	import pscd_pkg::*;
	int busy_d;
	int busy_q;
	always_comb begin
		busy_d = o_nv_busy ? busy_q + 1 : 0;
	end
	always_ff @(posedge i_core_clk) begin
		busy_q <= i_sys_rst ? 0 : busy_d;
	end
	// ==========================================
	// checks
	default clocking @(posedge i_core_clk);
	endclocking
	default disable iff (i_sys_rst);
	chk_busy_length: assert property (
		$fell(o_nv_busy) |-> busy_q == NV_WRITE_CYCLES) else $error("busy length");
	chk_busy_at_stop: assert property (
		$rose(o_nv_busy) |-> i_scl && i_sda) else $error("busy without stop");
	chk_busy_no_ack: assert property (
		o_nv_busy |-> o_sda_oe_n) else $error("driven while busy");
	chk_guard_blocks: assert property (
		$rose(o_nv_busy) |-> $past(i_write_guard_n, 6)) else $error("guarded write");
	chk_busy_wiper_hold: assert property (
		o_nv_busy |=> $stable(o_wiper_position)) else $error("wiper moved busy");
	chk_ack_release: assert property (
		$fell(o_sda_oe_n) |-> ##[1:80] $rose(o_sda_oe_n)) else $error("held data");
	chk_idle_released: assert property (
		i_scl [*8] |-> o_sda_oe_n) else $error("driven when idle");
	chk_open_drain: assert property (
		o_sda_out == 1'b0) else $error("data driven high");
	cover property ($rose(o_nv_busy));
	cover property ($fell(o_sda_oe_n));
	cover property ($changed(o_wiper_position));
endmodule
bind pscd_top pscd_top_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES))
	i_pscd_top_asserts (
	.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_scl(i_scl),
	.i_sda(i_sda), .i_write_guard_n(i_write_guard_n), .o_sda_out(o_sda_out),
	.o_sda_oe_n(o_sda_oe_n), .o_wiper_position(o_wiper_position),
	.o_nv_busy(o_nv_busy));

// ---- tb/pscd_master.sv ----
// two-wire bus master model for the decoder
`timescale 1ns/10ps
module pscd_master (
	// clock
	input wire logic i_core_clk,
	// bus
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda
);
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	// ==========================================
	// clock first, data a cycle later, four cycles a phase
	task automatic set(input logic c, input logic d);
		@(posedge i_core_clk);
		o_scl <= c;
		@(posedge i_core_clk);
		o_sda <= d;
		repeat (2) @(posedge i_core_clk);
	endtask
	task automatic pulse(input logic d);
		set(1'b0, d);
		set(1'b1, d);
	endtask
	task automatic fin();
		set(1'b1, 1'b1);
		repeat (8) @(posedge i_core_clk);
	endtask
	task automatic stop();
		pulse(1'b0);
		fin();
	endtask
	task automatic xfer(input logic [7:0] b, output logic [8:0] r);
		for (int k = 8; k >= 0; k--) begin
			pulse(k == 0 ? 1'b1 : b[k-1]);
			r = {r[7:0], i_sda};
		end
	endtask
endmodule

// ---- tb/pscd_bench.sv ----
// self-checking bench for the potentiometer command decoder
`timescale 1ns/10ps
module pscd_bench;
	import pscd_pkg::*;
	localparam logic [7:0] ADR = 8'hA9;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic guard_n = 1'b1;
	logic strap_low = 1'b1;
	logic strap_mid = 1'b0;
	logic strap_high = 1'b1;
	logic scl;
	logic m_sda;
	logic sda_out;
	logic oe_n;
	logic busy;
	logic [WIPER_W-1:0] wiper;
	logic [8:0] r;
	logic [7:0] bad [4] = '{8'h39, 8'hA8, 8'hA1, 8'hAD};
	logic [7:0] und [4] = '{8'h30, 8'hA4, 8'h94, 8'h21};
	int err_count = 0;
	int check_count = 0;
	int n;
	wire logic sda = m_sda & (oe_n | sda_out);
	always #25 clk = ~clk;
	pscd_master i_pscd_master (.i_core_clk(clk), .i_sda(sda),
		.o_scl(scl), .o_sda(m_sda));
	pscd_top #(.NV_WRITE_CYCLES(300)) i_pscd_top (.i_core_clk(clk),
		.i_sys_rst(rst), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out),
		.o_sda_oe_n(oe_n), .i_address_strap_low(strap_low),
		.i_address_strap_mid(strap_mid), .i_address_strap_high(strap_high),
		.i_write_guard_n(guard_n), .o_wiper_position(wiper),
		.o_nv_busy(busy));
	task automatic stop_test();
		$display("%0d checks, %0d errors", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] s, input logic [7:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic send(input logic [7:0] b, input logic a);
		i_pscd_master.xfer(b, r);
		check({7'h00, r[0]}, {7'h00, !a});
	endtask
	// kind 2: two bytes, 3: write data, 4: read data
	task automatic frame(input logic [7:0] ins, input logic [7:0] d,
		input int kind);
		i_pscd_master.set(1'b1, 1'b0);
		send(ADR, 1'b1);
		send(ins, 1'b1);
		if (kind == 3) begin
			send(d, 1'b1);
		end
		if (kind == 4) begin
			i_pscd_master.xfer(8'hFF, r);
			check(r[8:1], d);
		end
		i_pscd_master.stop();
	endtask
	task automatic poll();
		n = 0;
		r = 9'h1FF;
		while (r[0] !== 1'b0) begin
			if (n == 40) begin
				err_count++;
				stop_test();
			end
			i_pscd_master.set(1'b1, 1'b0);
			i_pscd_master.xfer(ADR, r);
			i_pscd_master.stop();
			n++;
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (5) @(posedge clk);
		foreach (bad[k]) begin
			i_pscd_master.set(1'b1, 1'b0);
			send(bad[k], 1'b0);
			i_pscd_master.stop();
		end
		// straps moved: old address refused, new one answered
		strap_low <= 1'b0;
		strap_mid <= 1'b1;
		strap_high <= 1'b0;
		i_pscd_master.set(1'b1, 1'b0);
		send(ADR, 1'b0);
		i_pscd_master.stop();
		i_pscd_master.set(1'b1, 1'b0);
		send(8'hA4, 1'b1);
		i_pscd_master.stop();
		strap_low <= 1'b1;
		strap_mid <= 1'b0;
		strap_high <= 1'b1;
		$display("test address done");
		frame(8'hA0, 8'h15, 3);
		check({2'b00, wiper}, 8'h15);
		frame(8'h90, 8'h15, 4);
		for (int k = 0; k < 4; k++) begin
			frame({4'hC, 2'(k), 2'b00}, 8'h30 + 8'(k), 3);
			poll();
			check(8'(n > 1), 8'h01);
			frame({4'hB, 2'(k), 2'b00}, 8'h30 + 8'(k), 4);
		end
		$display("test registers done");
		i_pscd_master.set(1'b1, 1'b0);
		send(ADR, 1'b1);
		send(8'hD8, 1'b1);
		check({2'b00, wiper}, 8'h15);
		i_pscd_master.stop();
		repeat (30) @(posedge clk);
		check({2'b00, wiper}, 8'h32);
		guard_n <= 1'b0;
		frame(8'hEC, 8'h00, 2);
		check({7'h00, busy}, 8'h00);
		frame(8'hBC, 8'h33, 4);
		guard_n <= 1'b1;
		frame(8'hEC, 8'h00, 2);
		check({7'h00, busy}, 8'h01);
		poll();
		frame(8'hBC, 8'h32, 4);
		$display("test transfer done");
		frame(8'hA0, 8'h3E, 3);
		i_pscd_master.set(1'b1, 1'b0);
		send(ADR, 1'b1);
		send(8'h20, 1'b1);
		i_pscd_master.pulse(1'b1);
		i_pscd_master.pulse(1'b1);
		i_pscd_master.set(1'b0, 1'b0);
		check({2'b00, wiper}, 8'h3F);
		i_pscd_master.set(1'b1, 1'b0);
		i_pscd_master.fin();
		check({2'b00, wiper}, 8'h3E);
		i_pscd_master.pulse(1'b1);
		repeat (8) @(posedge clk);
		check({2'b00, wiper}, 8'h3E);
		$display("test step done");
		foreach (und[k]) begin
			i_pscd_master.set(1'b1, 1'b0);
			send(ADR, 1'b1);
			send(und[k], 1'b0);
			i_pscd_master.stop();
		end
		check({2'b00, wiper}, 8'h3E);
		frame(8'hB0, 8'h30, 4);
		$display("test undefined done");
		stop_test();
	end
endmodule
